// File: rci_map.svh
// constants for the remote command interface: characters, depths, times
// assumes a 25 MHz system clock; included by the core
`ifndef RCI_MAP_SVH
`define RCI_MAP_SVH
`define RCI_CLK_HZ 25000000
`define RCI_REPLY_MS 500
`define RCI_SLOW_S 10
`define RCI_REPLY_CYC (`RCI_CLK_HZ / 1000 * `RCI_REPLY_MS)
`define RCI_SLOW_CYC (`RCI_CLK_HZ * `RCI_SLOW_S)
`define RCI_RXBUF_DEPTH 250
`define RCI_DEF_ADDR 5'h0A
`define RCI_CH_CR 8'h0D
`define RCI_CH_LF 8'h0A
`define RCI_CH_STAR 8'h2A
`define RCI_CH_QM 8'h3F
`define RCI_ASCII_BIT 7
`endif

// File: rci_pkg.sv
// types shared by the remote command interface
// assumes rci_map.svh for the numeric constants
package rci_pkg;
  // which port a byte stream belongs to
  typedef enum logic [1:0] {
    PORT_HOST, PORT_BARO, PORT_CTRL, PORT_PASS
  } port_t;
  // peripheral kinds the engine may ask to reach
  typedef enum logic [1:0] {
    PERI_BARO, PERI_VAC, PERI_CTRL, PERI_TEXT
  } peri_t;
  // one command byte on its way to the engine
  typedef struct packed {
    logic [7:0] data;
    logic last;
    port_t dest;
  } cmd_beat_t;
  // one outgoing reply byte
  typedef struct packed {
    logic [7:0] data;
    logic eoi;
    logic on_bus;
  } tx_beat_t;
endpackage : rci_pkg

// File: remote_command_interface.sv
// remote command front end: framing, lockout, reply pacing, bus buffer
// assumes byte-level serial and parallel-bus engines on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "rci_map.svh"
module remote_command_interface
  import rci_pkg::*;
#(
  parameter int DEPTH = `RCI_RXBUF_DEPTH,
  parameter int REPLY_CYC = `RCI_REPLY_CYC,
  parameter int SLOW_CYC = `RCI_SLOW_CYC
) (
  input wire logic sys_clk, // system clock
  input wire logic rst, // sync reset, high
  input wire logic ser_rx_valid, // serial byte, uart set as host
  input wire logic [7:0] ser_rx_data, // serial byte value
  input wire logic bus_rx_valid, // bus byte accepted
  input wire logic [7:0] bus_rx_data, // bus byte value
  input wire logic bus_rx_eoi, // eoi with bus byte
  input wire logic escape_key, // panel escape pin
  input wire logic lock_cmd, // keypad lock decoded
  input wire logic local_cmd, // return to local decoded
  input wire logic forward_text_cmd, // pass-through active
  input wire logic slow_cmd, // command may reach peripherals
  input wire peri_t peri_kind, // peripheral for slow command
  input wire logic crlf_mode, // 1 cr+lf on serial, 0 lf only; bus always lf only
  input wire logic addr_set_valid, // panel address write
  input wire logic [4:0] addr_set, // panel address
  input wire logic cmd_ready, // engine takes a byte
  input wire logic rep_valid, // reply byte offered
  input wire logic [7:0] rep_data, // reply byte
  input wire logic rep_last, // last reply byte
  input wire logic tx_ready, // link takes tx byte
  output cmd_beat_t cmd_out, // command byte to engine
  output logic cmd_valid, // command byte valid
  output logic rep_ready, // reply byte taken
  output tx_beat_t tx_out, // reply byte to link
  output logic tx_valid, // reply byte valid
  output logic nrfd_hold, // hold not-ready-for-data
  output logic remote_mode, // remote mode
  output logic key_lockout, // function keys locked
  output logic reply_late, // reply overdue
  output logic [4:0] bus_addr, // listen/talk address
  output logic ppoll_en // parallel poll response
);
  typedef enum {S_IDLE, S_WAIT, S_DATA, S_CR, S_LF} rst_st_t;
  // sync chain for escape pin
  logic [2:0] esc_sync_r;
  logic esc_lvl_r;
  logic esc_press;
  // link and mode state
  logic busy_r, on_bus_r, common_r, query_r, lock_r, remote_r;
  logic [7:0] prev_r;
  // bus receive buffer
  logic [7:0] mem [DEPTH];
  logic [$clog2(DEPTH)-1:0] wp_r, rp_r;
  logic [$clog2(DEPTH):0] cnt_r;
  logic [DEPTH-1:0] eoi_mem;
  logic msg_r; // terminator in buffer
  // two-entry output buffer
  cmd_beat_t sk0_r, sk1_r;
  logic v0_r, v1_r;
  // reply path
  rst_st_t st_r, st_nxt;
  logic [27:0] tmr_r;
  logic slow_r, suppress;
  logic in_v, take_in, bus_pop, push, pop;
  cmd_beat_t in_b;
  logic [7:0] in_d;
  logic in_eoi;

  // seven-bit ascii test for command bytes
  function automatic logic is_ascii(input logic [7:0] b);
    return !b[`RCI_ASCII_BIT];
  endfunction : is_ascii

  // map peripheral kind to its serial port
  function automatic port_t port_of(input peri_t k);
    case (k)
      PERI_BARO, PERI_VAC: return PORT_BARO;
      PERI_CTRL: return PORT_CTRL;
      default: return PORT_PASS;
    endcase
  endfunction : port_of

  // escape pin sync, change counts when stages 2 and 3 agree
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      esc_sync_r <= 3'h0;
      esc_lvl_r <= 1'b0;
    end else begin
      esc_sync_r <= {esc_sync_r[1:0], escape_key};
      if (esc_sync_r[1] == esc_sync_r[2]) esc_lvl_r <= esc_sync_r[2];
    end
  end
  assign esc_press = (esc_sync_r[1] == esc_sync_r[2]) && esc_sync_r[2] && !esc_lvl_r;

  // bus bytes leave the receive buffer when the skid has room
  assign bus_pop = (cnt_r != '0) && take_in && on_bus_r;
  assign in_d = on_bus_r ? mem[rp_r] : ser_rx_data;
  assign in_eoi = on_bus_r ? eoi_mem[rp_r] : 1'b0;
  always_comb begin
    in_v = on_bus_r ? (cnt_r != '0) : ser_rx_valid;
    in_b.data = in_d;
    // serial ends on cr, bus ends on lf with eoi
    in_b.last = on_bus_r ? (in_eoi && in_d == `RCI_CH_LF)
                         : (in_d == `RCI_CH_CR);
    in_b.dest = forward_text_cmd ? port_of(PERI_TEXT) : PORT_HOST;
  end
  // skid room: serial bytes that do not fit are lost, bus bytes wait
  assign take_in = !v1_r;
  assign push = in_v && take_in && is_ascii(in_d)
                && !(!on_bus_r && in_d == `RCI_CH_LF);
  assign pop = v0_r && cmd_ready;

  // bus receive buffer, 250 bytes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (bus_rx_valid && cnt_r != ($clog2(DEPTH)+1)'(DEPTH)) begin
        mem[wp_r] <= bus_rx_data;
        eoi_mem[wp_r] <= bus_rx_eoi;
        wp_r <= (wp_r == ($clog2(DEPTH))'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (bus_pop) rp_r <= (rp_r == ($clog2(DEPTH))'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + (bus_rx_valid && cnt_r != ($clog2(DEPTH)+1)'(DEPTH)) - bus_pop;
    end
  end

  // nrfd held from terminator until buffer drains, and while near full (248 or more bytes)
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      msg_r <= 1'b0;
      nrfd_hold <= 1'b0;
    end else begin
      if (bus_rx_valid && bus_rx_eoi) msg_r <= 1'b1;
      else if (cnt_r == '0) msg_r <= 1'b0;
      nrfd_hold <= msg_r || (bus_rx_valid && bus_rx_eoi)
                   || cnt_r >= ($clog2(DEPTH)+1)'(DEPTH-2);
    end
  end

  // two-entry buffer toward the command engine
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      v0_r <= 1'b0;
      v1_r <= 1'b0;
      sk0_r <= '0;
      sk1_r <= '0;
    end else begin
      if (pop) begin
        sk0_r <= v1_r ? sk1_r : in_b;
        v0_r <= v1_r || push;
        v1_r <= v1_r && push;
        if (v1_r && push) sk1_r <= in_b;
      end else if (push) begin
        if (!v0_r) begin
          sk0_r <= in_b;
          v0_r <= 1'b1;
        end else begin
          sk1_r <= in_b;
          v1_r <= 1'b1;
        end
      end
    end
  end
  assign cmd_out = sk0_r;
  assign cmd_valid = v0_r;

  // link ownership, command class and remote/lock state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      on_bus_r <= 1'b0;
      busy_r <= 1'b0;
      common_r <= 1'b0;
      query_r <= 1'b0;
      prev_r <= 8'h00;
      remote_r <= 1'b0;
      lock_r <= 1'b0;
    end else begin
      // link switches only while no command awaits its reply and the skid is empty
      if (!busy_r && !v0_r) begin
        if (cnt_r != '0) on_bus_r <= 1'b1;
        else on_bus_r <= 1'b0; // idle link falls back to serial
      end
      if (in_v && take_in) begin
        remote_r <= 1'b1;
        if (prev_r == 8'h00) common_r <= (in_d == `RCI_CH_STAR);
        if (in_b.last) begin
          query_r <= (prev_r == `RCI_CH_QM);
          busy_r <= 1'b1;
          prev_r <= 8'h00;
        end else if (in_d != `RCI_CH_LF) prev_r <= in_d;
      end
      if (st_r == S_LF && (tx_ready || !tx_valid)) busy_r <= 1'b0;
      else if (st_r == S_WAIT && suppress) busy_r <= 1'b0;
      if (lock_cmd) lock_r <= 1'b1;
      if (local_cmd || (esc_press && !lock_r)) begin
        remote_r <= 1'b0;
        lock_r <= 1'b0;
      end
    end
  end
  assign remote_mode = remote_r;
  assign key_lockout = remote_r;

  // bus common command without query gives no answer
  assign suppress = on_bus_r && common_r && !query_r;

  // reply sequencer
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      S_IDLE: if (busy_r) st_nxt = S_WAIT;
      S_WAIT: st_nxt = suppress ? S_IDLE : S_DATA;
      S_DATA: if (rep_valid && rep_ready && rep_last)
          st_nxt = on_bus_r ? S_LF : (crlf_mode ? S_CR : S_LF);
      S_CR: if (tx_ready || !tx_valid) st_nxt = S_LF;
      S_LF: if (tx_ready || !tx_valid) st_nxt = S_IDLE; // line feed loaded
      default: st_nxt = S_IDLE;
    endcase
  end

  // reply byte holding register, kept until the host reads it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= S_IDLE;
      tx_valid <= 1'b0;
      tx_out <= '0;
      rep_ready <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (tx_valid && tx_ready) tx_valid <= 1'b0;
      if (st_r == S_DATA && rep_valid && rep_ready) begin
        tx_valid <= 1'b1;
        tx_out <= '{data: rep_data, eoi: 1'b0, on_bus: on_bus_r};
      end else if ((st_r == S_CR || st_r == S_LF) && (!tx_valid || tx_ready)) begin
        tx_valid <= 1'b1;
        tx_out <= '{data: (st_r == S_CR) ? `RCI_CH_CR : `RCI_CH_LF,
                    eoi: on_bus_r && st_r == S_LF, on_bus: on_bus_r};
      end
      rep_ready <= (st_nxt == S_DATA) && !(rep_valid && rep_ready) && !(tx_valid && !tx_ready);
    end
  end

  // reply deadline timer, longer window for peripheral commands
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tmr_r <= '0;
      slow_r <= 1'b0;
      reply_late <= 1'b0;
    end else if (st_r == S_WAIT || st_r == S_DATA) begin
      if (st_r == S_WAIT) slow_r <= slow_cmd;
      tmr_r <= tmr_r + 1'b1;
      if (tmr_r == (slow_r ? 28'(SLOW_CYC) : 28'(REPLY_CYC))) reply_late <= 1'b1;
    end else begin
      tmr_r <= '0;
      reply_late <= 1'b0;
    end
  end

  // bus address, default ten, panel writable; no parallel poll
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_addr <= `RCI_DEF_ADDR;
      ppoll_en <= 1'b0;
    end else begin
      if (addr_set_valid) bus_addr <= addr_set;
      ppoll_en <= 1'b0;
    end
  end

  // checks
  AST_NRFD_FULL: assert property (@(posedge sys_clk) disable iff (rst)
    cnt_r >= ($clog2(DEPTH)+1)'(DEPTH-1) |=> nrfd_hold)
    else $error("nrfd released near full");
  AST_NO_OVF: assert property (@(posedge sys_clk) disable iff (rst)
    cnt_r <= ($clog2(DEPTH)+1)'(DEPTH))
    else $error("receive buffer overflow");
  AST_REMOTE: assert property (@(posedge sys_clk) disable iff (rst)
    in_v && take_in && !local_cmd |=> remote_mode && key_lockout)
    else $error("command did not enter remote");
  AST_ESC_LOCK: assert property (@(posedge sys_clk) disable iff (rst)
    lock_r && !local_cmd && remote_r |=> remote_r)
    else $error("escape left keypad lock");
  AST_LOCAL: assert property (@(posedge sys_clk) disable iff (rst)
    local_cmd && !(in_v && take_in) |=> !key_lockout)
    else $error("keys stay locked after local");
  AST_BUS_EOI: assert property (@(posedge sys_clk) disable iff (rst)
    tx_valid && tx_out.eoi |-> tx_out.data == `RCI_CH_LF && tx_out.on_bus)
    else $error("eoi without line feed");
  AST_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_out))
    else $error("reply lost before read");
  AST_ADDR: assert property (@(posedge sys_clk)
    $fell(rst) |-> bus_addr == `RCI_DEF_ADDR)
    else $error("bad default address");
  AST_ASCII: assert property (@(posedge sys_clk) disable iff (rst)
    cmd_valid |-> !cmd_out.data[`RCI_ASCII_BIT])
    else $error("non ascii command byte");
  AST_NO_PP: assert property (@(posedge sys_clk) disable iff (rst)
    !ppoll_en)
    else $error("parallel poll enabled");
  COV_SER_CMD: cover property (@(posedge sys_clk) disable iff (rst)
    cmd_valid && cmd_out.last && !on_bus_r);
  COV_BUS_REPLY: cover property (@(posedge sys_clk) disable iff (rst)
    tx_valid && tx_ready && tx_out.eoi);
  COV_SUPPRESS: cover property (@(posedge sys_clk) disable iff (rst)
    st_r == S_WAIT && suppress);
endmodule : remote_command_interface
`default_nettype wire

// File: link_sink.sv
// link side model: takes reply bytes from the block with random stalls
// assumes the block's clock; ready changes just after each rising edge
`timescale 1ns/1ps
`default_nettype none
module link_sink (
  input wire logic sys_clk, // system clock
  input wire logic rst, // sync reset, high
  input wire logic tx_valid, // byte offered by the block
  output logic tx_ready // byte taken
);
  // no handshake line beyond ready; stalls hold the reply in place
  always @(posedge sys_clk) begin
    if (rst) begin
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= ($urandom % 3) != 0;
    end
  end
endmodule : link_sink
`default_nettype wire

// File: remote_command_interface_tb.sv
// self-checking bench: queue model of command and reply streams
// assumes rci_pkg compiled first and link_sink as the reply consumer
`timescale 1ns/1ps
`default_nettype none
module remote_command_interface_tb;
  import rci_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, stall = 1'b0; // clock, reset, engine stall
  logic ser_rx_valid = 1'b0, bus_rx_valid = 1'b0, bus_rx_eoi = 1'b0; // rx strobes
  logic [7:0] ser_rx_data = 8'h00, bus_rx_data = 8'h00, rep_data = 8'h00; // bytes
  logic escape_key = 1'b0, lock_cmd = 1'b0, local_cmd = 1'b0; // panel and decode
  logic forward_text_cmd = 1'b0, slow_cmd = 1'b0, crlf_mode = 1'b1; // modes
  peri_t peri_kind = PERI_BARO; // peripheral kind
  logic addr_set_valid = 1'b0, cmd_ready = 1'b0, rep_valid = 1'b0, rep_last = 1'b0;
  logic [4:0] addr_set = 5'h00; // panel address
  logic tx_ready, rep_ready, tx_valid, cmd_valid, nrfd_hold; // handshakes
  logic remote_mode, key_lockout, reply_late, ppoll_en; // levels
  logic [4:0] bus_addr; // bus address
  cmd_beat_t cmd_out; // command beat
  tx_beat_t tx_out; // reply beat
  cmd_beat_t exp_cmd[$]; // expected command beats
  tx_beat_t exp_tx[$]; // expected reply beats
  int error_cnt = 0, checks = 0; // counters
  string big_cmd = ""; // long bus command

  remote_command_interface #(.REPLY_CYC(50), .SLOW_CYC(200)) u_remote_command_interface (
    .sys_clk(sys_clk), .rst(rst), .ser_rx_valid(ser_rx_valid), .ser_rx_data(ser_rx_data),
    .bus_rx_valid(bus_rx_valid), .bus_rx_data(bus_rx_data), .bus_rx_eoi(bus_rx_eoi),
    .escape_key(escape_key), .lock_cmd(lock_cmd), .local_cmd(local_cmd),
    .forward_text_cmd(forward_text_cmd), .slow_cmd(slow_cmd), .peri_kind(peri_kind),
    .crlf_mode(crlf_mode), .addr_set_valid(addr_set_valid), .addr_set(addr_set),
    .cmd_ready(cmd_ready), .rep_valid(rep_valid), .rep_data(rep_data), .rep_last(rep_last),
    .tx_ready(tx_ready), .cmd_out(cmd_out), .cmd_valid(cmd_valid), .rep_ready(rep_ready),
    .tx_out(tx_out), .tx_valid(tx_valid), .nrfd_hold(nrfd_hold), .remote_mode(remote_mode),
    .key_lockout(key_lockout), .reply_late(reply_late), .bus_addr(bus_addr),
    .ppoll_en(ppoll_en));
  link_sink u_link_sink (.sys_clk(sys_clk), .rst(rst), .tx_valid(tx_valid),
    .tx_ready(tx_ready));

  always #20 sys_clk = ~sys_clk; // 25 MHz
  // engine side ready, random unless a stall is wanted
  always @(posedge sys_clk) cmd_ready <= !stall && (($urandom % 4) != 0);

  task automatic chk_cmd(input cmd_beat_t g, input cmd_beat_t e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t cmd got %h exp %h", $time, g, e);
    end
  endtask : chk_cmd
  task automatic chk_tx(input tx_beat_t g, input tx_beat_t e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t tx got %h exp %h", $time, g, e);
    end
  endtask : chk_tx
  task automatic chk_bit(input logic g, input logic e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t flag got %h exp %h", $time, g, e);
    end
  endtask : chk_bit
  task automatic end_sim;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  // every accepted beat is held against the model queues
  always @(posedge sys_clk) begin
    if (!rst && cmd_valid === 1'b1 && cmd_ready) begin
      if (exp_cmd.size() == 0) chk_bit(1'b1, 1'b0);
      else chk_cmd(cmd_out, exp_cmd.pop_front());
    end
    if (!rst && tx_valid === 1'b1 && tx_ready) begin
      if (exp_tx.size() == 0) chk_bit(1'b1, 1'b0);
      else chk_tx(tx_out, exp_tx.pop_front());
    end
  end

  // serial bytes spaced out; line feed and high-bit bytes never reach the engine
  task automatic ser_cmd(input string s);
    cmd_beat_t b;
    for (int i = 0; i < s.len(); i++) begin
      b.data = s[i];
      b.last = (b.data == 8'h0D);
      b.dest = forward_text_cmd ? PORT_PASS : PORT_HOST;
      if (b.data != 8'h0A && !b.data[7]) exp_cmd.push_back(b);
      ser_rx_valid <= 1'b1;
      ser_rx_data <= b.data;
      @(posedge sys_clk);
      ser_rx_valid <= 1'b0;
      repeat (6) @(posedge sys_clk);
    end
  endtask : ser_cmd

  // bus burst with the engine stalled, eoi on the final line feed
  task automatic bus_cmd(input string s);
    cmd_beat_t b;
    int n;
    stall = 1'b1;
    for (int i = 0; i < s.len(); i++) begin
      b.data = s[i];
      b.last = (i == s.len() - 1);
      b.dest = PORT_HOST;
      exp_cmd.push_back(b);
      bus_rx_valid <= 1'b1;
      bus_rx_data <= b.data;
      bus_rx_eoi <= b.last;
      @(posedge sys_clk);
    end
    bus_rx_valid <= 1'b0;
    bus_rx_eoi <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk_bit(nrfd_hold, 1'b1);
    stall = 1'b0;
    for (n = 0; exp_cmd.size() > 0 && n < 1000; n++) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
    chk_bit(nrfd_hold, 1'b0);
  endtask : bus_cmd

  // engine reply; the block appends its own terminator
  task automatic reply(input string s, input logic bus);
    tx_beat_t t;
    int n;
    for (n = 0; rep_ready !== 1'b1 && n < 300; n++) @(posedge sys_clk);
    t.eoi = 1'b0;
    t.on_bus = bus;
    for (int i = 0; i < s.len(); i++) begin
      t.data = s[i];
      exp_tx.push_back(t);
      rep_valid <= 1'b1;
      rep_data <= t.data;
      rep_last <= (i == s.len() - 1);
      do @(posedge sys_clk); while (rep_ready !== 1'b1);
    end
    rep_valid <= 1'b0;
    t.data = 8'h0D;
    if (crlf_mode && !bus) exp_tx.push_back(t);
    t.data = 8'h0A;
    t.eoi = bus;
    exp_tx.push_back(t);
    for (n = 0; exp_tx.size() > 0 && n < 300; n++) @(posedge sys_clk);
    chk_bit(exp_tx.size() == 0, 1'b1);
  endtask : reply

  initial begin
    void'($urandom(32'h33F1));
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk_bit(bus_addr === 5'h0A, 1'b1);
    chk_bit(ppoll_en, 1'b0);
    chk_bit(remote_mode, 1'b0);
    ser_cmd("A\200B\012\015");
    chk_bit(remote_mode, 1'b1);
    chk_bit(key_lockout, 1'b1);
    reply("OK", 1'b0);
    crlf_mode <= 1'b0;
    forward_text_cmd <= 1'b1;
    @(posedge sys_clk);
    ser_cmd("P\015");
    reply("R", 1'b0);
    forward_text_cmd <= 1'b0;
    @(posedge sys_clk);
    ser_cmd("L\015");
    repeat (60) @(posedge sys_clk);
    chk_bit(reply_late, 1'b1);
    reply("Z", 1'b0);
    slow_cmd <= 1'b1;
    peri_kind <= peri_t'($urandom % 3);
    ser_cmd("S\015");
    repeat (60) @(posedge sys_clk);
    chk_bit(reply_late, 1'b0);
    repeat (160) @(posedge sys_clk);
    chk_bit(reply_late, 1'b1);
    reply("Y", 1'b0);
    slow_cmd <= 1'b0;
    // escape drops to local and frees the keys
    escape_key <= 1'b1;
    repeat (6) @(posedge sys_clk);
    escape_key <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk_bit(remote_mode, 1'b0);
    chk_bit(key_lockout, 1'b0);
    // serial common command is answered; keypad lock defeats escape
    ser_cmd("*C\015");
    reply("1", 1'b0);
    lock_cmd <= 1'b1;
    @(posedge sys_clk);
    lock_cmd <= 1'b0;
    escape_key <= 1'b1;
    repeat (6) @(posedge sys_clk);
    escape_key <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk_bit(remote_mode, 1'b1);
    local_cmd <= 1'b1;
    @(posedge sys_clk);
    local_cmd <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk_bit(remote_mode, 1'b0);
    chk_bit(key_lockout, 1'b0);
    addr_set_valid <= 1'b1;
    addr_set <= 5'h03;
    @(posedge sys_clk);
    addr_set_valid <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk_bit(bus_addr === 5'h03, 1'b1);
    // long bus command fills the buffer past its nrfd threshold
    for (int i = 0; i < 250; i++) big_cmd = {big_cmd, "a"};
    bus_cmd({big_cmd, "\012"});
    reply("W", 1'b1);
    // bus: common command without query gets no reply phase
    bus_cmd("*C\012");
    repeat (10) @(posedge sys_clk);
    chk_bit(rep_ready, 1'b0);
    bus_cmd("*I?\012");
    reply("V", 1'b1);
    chk_bit(remote_mode, 1'b1);
    chk_bit(exp_cmd.size() == 0, 1'b1);
    end_sim();
  end

  // hang guard, well past the expected thousand or so cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    end_sim();
  end
endmodule : remote_command_interface_tb
`default_nettype wire
